/* bmx_regs.svh */
`ifndef BMX_REGS_SVH
`define BMX_REGS_SVH

`define BMX_PC_W           16
`define BMX_K_W            12

`define BMX_FLAG_C         0
`define BMX_FLAG_Z         1
`define BMX_FLAG_N         2
`define BMX_FLAG_V         3
`define BMX_FLAG_S         4
`define BMX_FLAG_H         5
`define BMX_FLAG_T         6
`define BMX_FLAG_I         7

`define BMX_CYC_MUL        3'h2
`define BMX_CYC_CMP        3'h1
`define BMX_CYC_JMP_REL    3'h2
`define BMX_CYC_JMP_IND    3'h2
`define BMX_CYC_JMP_DIR    3'h3
`define BMX_CYC_CALL_REL   3'h3
`define BMX_CYC_CALL_IND   3'h3
`define BMX_CYC_CALL_DIR   3'h4
`define BMX_CYC_RET        3'h4
`define BMX_CYC_BR_NOT     3'h1
`define BMX_CYC_BR_TAKEN   3'h2
`define BMX_CYC_SKIP_NONE  3'h1
`define BMX_CYC_SKIP_ONE   3'h2
`define BMX_CYC_SKIP_TWO   3'h3

`define BMX_PC_STEP_ONE    16'h0001
`define BMX_PC_STEP_TWO    16'h0002
`define BMX_PC_STEP_THREE  16'h0003

`define BMX_STATUS_RST     8'h00
`define BMX_PC_RST         16'h0000

`endif

/* bmx_pkg.sv */
package bmx_pkg;
  `include "bmx_regs.svh"

  typedef enum logic [4:0] {
    OP_NOP, OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
    OP_SIGNED_BY_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY_UNSIGNED,
    OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED,
    OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_DIRECT_JUMP,
    OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_DIRECT_CALL,
    OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_WITH_CONSTANT,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET, OP_BRANCH
  } bmx_op_t;

  typedef enum logic [4:0] {
    BR_STATUS_BIT_SET, BR_STATUS_BIT_CLEAR, BR_EQ, BR_NE, BR_CS, BR_CC,
    BR_SH, BR_LO, BR_MI, BR_PL, BR_SIGNED_GE, BR_SIGNED_LT, BR_HS, BR_HC,
    BR_TS, BR_TC, BR_VS, BR_VC, BR_IRQ_ENABLED, BR_IRQ_DISABLED
  } bmx_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } bmx_fsm_t;

  typedef struct packed {
    bmx_op_t                op;
    bmx_cond_t              cond;
    logic [7:0]             rd;
    logic [7:0]             rr;
    logic [2:0]             bsel;
    logic [7:0]             io_val;
    logic                   next_two_word;
    logic [`BMX_PC_W-1:0]   pc;
    logic [`BMX_K_W-1:0]    k;
    logic [`BMX_PC_W-1:0]   target;
    logic [`BMX_PC_W-1:0]   z_ptr;
    logic [`BMX_PC_W-1:0]   stack_pc;
    logic [7:0]             status;
  } bmx_req_t;

  typedef struct packed {
    logic [`BMX_PC_W-1:0]   pc;
    logic                   pc_load;
    logic [`BMX_PC_W-1:0]   push_pc;
    logic                   push_we;
    logic [15:0]            prod;
    logic                   prod_we;
    logic [7:0]             status;
    logic                   status_we;
    logic                   done;
  } bmx_res_t;

  typedef struct packed {
    bmx_fsm_t               fsm;
    logic [2:0]             cnt;
    logic                   busy;
    bmx_op_t                op;
    bmx_res_t               res;
  } bmx_state_t;
endpackage

/* bmx_exec.sv */
`timescale 1ns/100ps
`include "bmx_regs.svh"

// Summary of operation
// - Signed-by-unsigned multiply writes the 16-bit product to R1:R0, updates only Z and C, in two cycles.
// - The three fractional multiplies shift the product left by one, write R1:R0, update only Z and C, in two cycles.
// - Relative jump goes to PC+k+1 and indirect jump to Z in two cycles, direct jump to target in three, no flags touched.
// - Relative and indirect calls take three cycles, direct call takes four, and no call alters a flag.
// - Compare-skip-equal advances PC by 2 or 3 when the registers match, else by 1, in 1, 2 or 3 cycles, flags kept.
// - The three compares form the difference without storing it, update Z, N, V, S, C and H, in one cycle.
// - Register bit skips skip on a clear or set bit, advance PC by 2 or 3, take 1 to 3 cycles, keep flags.
// - I/O bit skips skip on a clear or set bit, advance PC by 2 or 3, take 1 to 3 cycles, keep flags.
// - Generic branches test any status bit set or clear, go to PC+k+1 when taken, take 1 or 2 cycles, keep flags.
// - Named branches test Z for equal, C for carry and lower or higher, and N for minus and plus.
// - Signed greater-or-equal branches when N xor V is 0, less-than when it is 1, with one extra cycle when taken.
// - Half-carry branches go to PC+k+1 on H set or clear, one cycle not taken and two taken.
// - T-flag branches go to PC+k+1 on T set or clear in one or two cycles without modifying flags.
// - Overflow branches go to PC+k+1 on V set or clear in one or two cycles without modifying flags.
// - Interrupt-enable branches go to PC+k+1 on I set or clear in one or two cycles without modifying flags.
module bmx_exec (
  input  wire logic     clock,
  input  wire logic     arst_n,
  input  wire logic     req_valid,
  input  bmx_pkg::bmx_req_t req,
  output logic          busy,
  output bmx_pkg::bmx_res_t res
);
  import bmx_pkg::*;

  bmx_state_t st_ff;
  bmx_state_t nxt_st;

  always_comb begin
    logic                 take;
    logic                 br;
    logic                 skip;
    logic                 sa;
    logic                 sb;
    logic                 frac;
    logic                 r3;
    logic                 r7;
    logic                 vflag;
    logic [2:0]           cyc;
    logic [8:0]           ma;
    logic [8:0]           mb;
    logic [17:0]          pfull;
    logic [8:0]           diff;
    logic [7:0]           stat;
    logic [`BMX_PC_W-1:0] pc1;
    logic [`BMX_PC_W-1:0] pc_rel;
    take   = req_valid && (st_ff.fsm == ST_IDLE);
    br     = 1'b0;
    skip   = 1'b0;
    sa     = 1'b0;
    sb     = 1'b0;
    frac   = 1'b0;
    cyc    = `BMX_CYC_CMP;
    stat   = req.status;
    pc1    = req.pc + `BMX_PC_STEP_ONE;
    pc_rel = req.pc + {{(`BMX_PC_W-`BMX_K_W){req.k[`BMX_K_W-1]}}, req.k}
             + `BMX_PC_STEP_ONE;
    nxt_st = st_ff;
    nxt_st.res.pc_load   = 1'b0;
    nxt_st.res.push_we   = 1'b0;
    nxt_st.res.prod_we   = 1'b0;
    nxt_st.res.status_we = 1'b0;
    nxt_st.res.done      = 1'b0;

    // Operand signedness for the multiplier family
    case (req.op)
      OP_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_SIGNED: begin
        sa = 1'b1;
        sb = 1'b1;
      end
      OP_SIGNED_BY_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY_MIXED: begin
        sa = 1'b1;
      end
      default: begin
        sa = 1'b0;
      end
    endcase
    frac  = (req.op == OP_FRACTIONAL_MULTIPLY_UNSIGNED) ||
            (req.op == OP_FRACTIONAL_MULTIPLY_SIGNED) ||
            (req.op == OP_FRACTIONAL_MULTIPLY_MIXED);
    ma    = {sa & req.rd[7], req.rd};
    mb    = {sb & req.rr[7], req.rr};
    pfull = 18'($signed({{9{ma[8]}}, ma}) * $signed({{9{mb[8]}}, mb}));

    // Compare difference; carry term only for the carry variant
    diff  = {1'b0, req.rd} - {1'b0, req.rr}
            - {8'h00, (req.op == OP_COMPARE_WITH_CARRY) &
                      req.status[`BMX_FLAG_C]};
    r3    = diff[3];
    r7    = diff[7];
    vflag = (req.rd[7] & ~req.rr[7] & ~r7) | (~req.rd[7] & req.rr[7] & r7);

    case (req.cond)
      BR_STATUS_BIT_SET:   br = req.status[req.bsel];
      BR_STATUS_BIT_CLEAR: br = ~req.status[req.bsel];
      BR_EQ:               br = req.status[`BMX_FLAG_Z];
      BR_NE:               br = ~req.status[`BMX_FLAG_Z];
      BR_CS, BR_LO:        br = req.status[`BMX_FLAG_C];
      BR_CC, BR_SH:        br = ~req.status[`BMX_FLAG_C];
      BR_MI:               br = req.status[`BMX_FLAG_N];
      BR_PL:               br = ~req.status[`BMX_FLAG_N];
      BR_SIGNED_GE:        br = ~(req.status[`BMX_FLAG_N] ^
                                  req.status[`BMX_FLAG_V]);
      BR_SIGNED_LT:        br = req.status[`BMX_FLAG_N] ^
                                req.status[`BMX_FLAG_V];
      BR_HS:               br = req.status[`BMX_FLAG_H];
      BR_HC:               br = ~req.status[`BMX_FLAG_H];
      BR_TS:               br = req.status[`BMX_FLAG_T];
      BR_TC:               br = ~req.status[`BMX_FLAG_T];
      BR_VS:               br = req.status[`BMX_FLAG_V];
      BR_VC:               br = ~req.status[`BMX_FLAG_V];
      BR_IRQ_ENABLED:      br = req.status[`BMX_FLAG_I];
      BR_IRQ_DISABLED:     br = ~req.status[`BMX_FLAG_I];
      default:             br = 1'b0;
    endcase

    case (req.op)
      OP_COMPARE_SKIP_EQUAL: skip = (req.rd == req.rr);
      OP_SKIP_REG_BIT_CLEAR: skip = ~req.rr[req.bsel];
      OP_SKIP_REG_BIT_SET:   skip = req.rr[req.bsel];
      OP_SKIP_IO_BIT_CLEAR:  skip = ~req.io_val[req.bsel];
      OP_SKIP_IO_BIT_SET:    skip = req.io_val[req.bsel];
      default:               skip = 1'b0;
    endcase

    case (st_ff.fsm)
      ST_IDLE: begin
        if (take) begin
          nxt_st.fsm    = ST_RUN;
          nxt_st.busy   = 1'b1;
          nxt_st.op     = req.op;
          nxt_st.res.pc = pc1;
          case (req.op)
            OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
            OP_SIGNED_BY_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY_UNSIGNED,
            OP_FRACTIONAL_MULTIPLY_SIGNED,
            OP_FRACTIONAL_MULTIPLY_MIXED: begin
              cyc = `BMX_CYC_MUL;
              nxt_st.res.prod = frac ? {pfull[14:0], 1'b0}
                                     : pfull[15:0];
              stat[`BMX_FLAG_C] = pfull[15];
              stat[`BMX_FLAG_Z] = frac ? (pfull[14:0] == 15'h0000)
                                       : (pfull[15:0] == 16'h0000);
            end
            OP_RELATIVE_JUMP: begin
              cyc           = `BMX_CYC_JMP_REL;
              nxt_st.res.pc = pc_rel;
            end
            OP_INDIRECT_JUMP: begin
              cyc           = `BMX_CYC_JMP_IND;
              nxt_st.res.pc = req.z_ptr;
            end
            OP_DIRECT_JUMP: begin
              cyc           = `BMX_CYC_JMP_DIR;
              nxt_st.res.pc = req.target;
            end
            OP_RELATIVE_CALL: begin
              cyc                = `BMX_CYC_CALL_REL;
              nxt_st.res.pc      = pc_rel;
              nxt_st.res.push_pc = pc1;
            end
            OP_INDIRECT_CALL: begin
              cyc                = `BMX_CYC_CALL_IND;
              nxt_st.res.pc      = req.z_ptr;
              nxt_st.res.push_pc = pc1;
            end
            OP_DIRECT_CALL: begin
              // Return address skips the second opcode word
              cyc                = `BMX_CYC_CALL_DIR;
              nxt_st.res.pc      = req.target;
              nxt_st.res.push_pc = req.pc + `BMX_PC_STEP_TWO;
            end
            OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
              cyc           = `BMX_CYC_RET;
              nxt_st.res.pc = req.stack_pc;
              if (req.op == OP_INTERRUPT_RETURN) begin
                stat[`BMX_FLAG_I] = 1'b1;
              end
            end
            OP_COMPARE, OP_COMPARE_WITH_CARRY,
            OP_COMPARE_WITH_CONSTANT: begin
              cyc = `BMX_CYC_CMP;
              stat[`BMX_FLAG_H] = (~req.rd[3] & req.rr[3]) |
                                  (req.rr[3] & r3) | (r3 & ~req.rd[3]);
              stat[`BMX_FLAG_V] = vflag;
              stat[`BMX_FLAG_N] = r7;
              stat[`BMX_FLAG_S] = r7 ^ vflag;
              stat[`BMX_FLAG_C] = (~req.rd[7] & req.rr[7]) |
                                  (req.rr[7] & r7) | (r7 & ~req.rd[7]);
              // Carry variant keeps Z clear once a higher byte differed
              stat[`BMX_FLAG_Z] = (diff[7:0] == 8'h00) &
                ((req.op != OP_COMPARE_WITH_CARRY) |
                 req.status[`BMX_FLAG_Z]);
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
            OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_SET: begin
              if (!skip) begin
                cyc = `BMX_CYC_SKIP_NONE;
              end else if (req.next_two_word) begin
                cyc           = `BMX_CYC_SKIP_TWO;
                nxt_st.res.pc = req.pc + `BMX_PC_STEP_THREE;
              end else begin
                cyc           = `BMX_CYC_SKIP_ONE;
                nxt_st.res.pc = req.pc + `BMX_PC_STEP_TWO;
              end
            end
            OP_BRANCH: begin
              cyc = br ? `BMX_CYC_BR_TAKEN : `BMX_CYC_BR_NOT;
              if (br) begin
                nxt_st.res.pc = pc_rel;
              end
            end
            default: begin
              cyc = `BMX_CYC_CMP;
            end
          endcase
          nxt_st.res.status = stat;
          nxt_st.cnt        = cyc;
        end
      end
      ST_RUN: begin
        nxt_st.cnt = st_ff.cnt - 3'h1;
        if (st_ff.cnt == 3'h1) begin
          nxt_st.fsm         = ST_IDLE;
          nxt_st.busy        = 1'b0;
          nxt_st.res.done    = 1'b1;
          nxt_st.res.pc_load = (st_ff.op != OP_NOP);
          nxt_st.res.push_we = (st_ff.op == OP_RELATIVE_CALL) ||
                               (st_ff.op == OP_INDIRECT_CALL) ||
                               (st_ff.op == OP_DIRECT_CALL);
          nxt_st.res.prod_we = (st_ff.op >= OP_MULTIPLY_UNSIGNED) &&
                               (st_ff.op <= OP_FRACTIONAL_MULTIPLY_MIXED);
          // Jumps, calls, skips and branches leave the flags alone
          nxt_st.res.status_we = nxt_st.res.prod_we ||
                                 (st_ff.op == OP_INTERRUPT_RETURN) ||
                                 (st_ff.op == OP_COMPARE) ||
                                 (st_ff.op == OP_COMPARE_WITH_CARRY) ||
                                 (st_ff.op == OP_COMPARE_WITH_CONSTANT);
        end
      end
      default: begin
        nxt_st.fsm  = ST_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff            <= '0;
      st_ff.fsm        <= ST_IDLE;
      st_ff.res.pc     <= `BMX_PC_RST;
      st_ff.res.status <= `BMX_STATUS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign res  = st_ff.res;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence take_s(bmx_op_t o);
    req_valid && (st_ff.fsm == ST_IDLE) && (req.op == o);
  endsequence

  // Done is registered: a two-cycle op shows it at the third edge after take
  sequence finish_s;
    !res.done ##1 res.done;
  endsequence

  mul_two_cycles_a: assert property (
    take_s(OP_SIGNED_BY_UNSIGNED_MULTIPLY) |->
      ##1 !res.done ##1 finish_s ##0 (res.prod_we && res.status_we))
    else $error("multiply did not finish in two cycles");

  frac_shift_a: assert property (
    take_s(OP_FRACTIONAL_MULTIPLY_SIGNED) |->
      ##3 (res.prod_we && res.prod ==
           (({{8{$past(req.rd[7], 3)}}, $past(req.rd, 3)} *
             {{8{$past(req.rr[7], 3)}}, $past(req.rr, 3)}) << 1)))
    else $error("fractional product not shifted");

  rel_jump_a: assert property (
    take_s(OP_RELATIVE_JUMP) |->
      ##3 (res.pc_load && !res.status_we && res.pc ==
           $past(req.pc, 3) + {{4{$past(req.k[11], 3)}}, $past(req.k, 3)}
           + 16'h0001))
    else $error("relative jump target or timing wrong");

  direct_call_a: assert property (
    take_s(OP_DIRECT_CALL) |->
      ##1 !res.done [*4] ##1 (res.push_we &&
           res.push_pc == $past(req.pc, 5) + 16'h0002))
    else $error("direct call push wrong");

  skip_equal_a: assert property (
    take_s(OP_COMPARE_SKIP_EQUAL) ##0 ((req.rd == req.rr) &&
    !req.next_two_word) |->
      ##3 (res.done && res.pc == $past(req.pc, 3) + 16'h0002))
    else $error("equal skip wrong");

  compare_one_a: assert property (
    take_s(OP_COMPARE) |-> ##2 (res.status_we &&
      res.status[`BMX_FLAG_Z] == ($past(req.rd, 2) == $past(req.rr, 2))))
    else $error("compare flags or timing wrong");

  branch_flags_a: assert property (
    res.done && ($past(st_ff.op) == OP_BRANCH) |-> !res.status_we)
    else $error("branch modified flags");

  signed_ge_a: assert property (
    take_s(OP_BRANCH) ##0 ((req.cond == BR_SIGNED_GE) &&
    !(req.status[`BMX_FLAG_N] ^ req.status[`BMX_FLAG_V])) |->
      ##2 finish_s)
    else $error("signed branch timing wrong");

  irq_return_a: assert property (
    take_s(OP_INTERRUPT_RETURN) |->
      ##5 (res.status_we && res.status[`BMX_FLAG_I] &&
           res.pc == $past(req.stack_pc, 5)))
    else $error("interrupt return wrong");
endmodule

/* tb_branch_multiply_exec_unit.sv */
`timescale 1ns/100ps
`include "bmx_regs.svh"

`define TB_CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); \
  end \
end

module tb_branch_multiply_exec_unit;
  import bmx_pkg::*;

  typedef struct packed {
    logic [2:0] n;
    bmx_res_t   r;
  } bmx_exp_t;

  logic      clock;
  logic      arst_n;
  logic      req_valid;
  bmx_req_t  req;
  logic      busy;
  bmx_res_t  res;
  bmx_exp_t  want;
  integer    seed;
  integer    mismatches;
  integer    cmp_count;
  integer    cyc;
  integer    end_cyc;
  integer    idx;
  logic      inflight;

  bmx_exec bmx_exec_inst (
    .clock     (clock),
    .arst_n    (arst_n),
    .req_valid (req_valid),
    .req       (req),
    .busy      (busy),
    .res       (res)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic cond_met(bmx_req_t q);
    logic [7:0] s;
    s = q.status;
    case (q.cond)
      BR_STATUS_BIT_SET:   return s[q.bsel];
      BR_STATUS_BIT_CLEAR: return !s[q.bsel];
      BR_EQ:               return s[`BMX_FLAG_Z];
      BR_NE:               return !s[`BMX_FLAG_Z];
      BR_CS, BR_LO:        return s[`BMX_FLAG_C];
      BR_CC, BR_SH:        return !s[`BMX_FLAG_C];
      BR_MI:               return s[`BMX_FLAG_N];
      BR_PL:               return !s[`BMX_FLAG_N];
      BR_SIGNED_GE:        return !(s[`BMX_FLAG_N] ^ s[`BMX_FLAG_V]);
      BR_SIGNED_LT:        return s[`BMX_FLAG_N] ^ s[`BMX_FLAG_V];
      BR_HS:               return s[`BMX_FLAG_H];
      BR_HC:               return !s[`BMX_FLAG_H];
      BR_TS:               return s[`BMX_FLAG_T];
      BR_TC:               return !s[`BMX_FLAG_T];
      BR_VS:               return s[`BMX_FLAG_V];
      BR_VC:               return !s[`BMX_FLAG_V];
      BR_IRQ_ENABLED:      return s[`BMX_FLAG_I];
      default:             return !s[`BMX_FLAG_I];
    endcase
  endfunction

  function automatic bmx_exp_t model(bmx_req_t q);
    bmx_exp_t    e;
    logic [15:0] p;
    logic [15:0] sk;
    logic [8:0]  d;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  r;
    logic        t;
    logic        compare_with_carry;
    e = '0;
    e.r.done = 1'b1;
    e.r.pc_load = 1'b1;
    e.r.status = q.status;
    e.n = 3'h1;
    t = 1'b0;
    sk = {{4{q.k[11]}}, q.k};
    e.r.pc = q.pc + 16'h0001;
    a = q.rd;
    b = q.rr;
    case (q.op)
      OP_MULTIPLY_UNSIGNED, OP_FRACTIONAL_MULTIPLY_UNSIGNED: p = a * b;
      OP_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_SIGNED:
        p = $signed(a) * $signed(b);
      default: p = $signed(a) * $signed({1'b0, b});
    endcase
    case (q.op)
      OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED,
      OP_SIGNED_BY_UNSIGNED_MULTIPLY, OP_FRACTIONAL_MULTIPLY_UNSIGNED,
      OP_FRACTIONAL_MULTIPLY_SIGNED, OP_FRACTIONAL_MULTIPLY_MIXED: begin
        e.r.status[`BMX_FLAG_C] = p[15];
        if (q.op >= OP_FRACTIONAL_MULTIPLY_UNSIGNED) p = p << 1;
        e.r.status[`BMX_FLAG_Z] = (p == 16'h0000);
        e.r.prod = p;
        e.r.prod_we = 1'b1;
        e.r.status_we = 1'b1;
        e.n = 3'h2;
      end
      OP_RELATIVE_JUMP: begin e.r.pc = q.pc + sk + 16'h0001; e.n = 3'h2; end
      OP_INDIRECT_JUMP: begin e.r.pc = q.z_ptr; e.n = 3'h2; end
      OP_DIRECT_JUMP:   begin e.r.pc = q.target; e.n = 3'h3; end
      OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_DIRECT_CALL: begin
        e.r.push_we = 1'b1;
        e.r.push_pc = q.pc + 16'h0001;
        e.n = 3'h3;
        e.r.pc = (q.op == OP_INDIRECT_CALL) ? q.z_ptr : q.pc + sk + 16'h0001;
        if (q.op == OP_DIRECT_CALL) begin
          e.r.pc = q.target;
          e.r.push_pc = q.pc + 16'h0002;
          e.n = 3'h4;
        end
      end
      OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
        e.r.pc = q.stack_pc;
        e.n = 3'h4;
        e.r.status_we = (q.op == OP_INTERRUPT_RETURN);
        e.r.status[`BMX_FLAG_I] = 1'b1;
        if (q.op == OP_SUBROUTINE_RETURN) e.r.status = q.status;
      end
      OP_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_WITH_CONSTANT: begin
        compare_with_carry = (q.op == OP_COMPARE_WITH_CARRY);
        d = {1'b0, a} - {1'b0, b} - {8'h00, compare_with_carry & q.status[`BMX_FLAG_C]};
        r = d[7:0];
        e.r.status[`BMX_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        e.r.status[`BMX_FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
        e.r.status[`BMX_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        e.r.status[`BMX_FLAG_N] = r[7];
        e.r.status[`BMX_FLAG_S] = r[7] ^ e.r.status[`BMX_FLAG_V];
        e.r.status[`BMX_FLAG_Z] = (r == 8'h00) & (!compare_with_carry | q.status[`BMX_FLAG_Z]);
        e.r.status_we = 1'b1;
      end
      OP_COMPARE_SKIP_EQUAL: t = (a == b);
      OP_SKIP_REG_BIT_CLEAR: t = !b[q.bsel];
      OP_SKIP_REG_BIT_SET:   t = b[q.bsel];
      OP_SKIP_IO_BIT_CLEAR:  t = !q.io_val[q.bsel];
      OP_SKIP_IO_BIT_SET:    t = q.io_val[q.bsel];
      default: if (cond_met(q)) begin
        e.r.pc = q.pc + sk + 16'h0001;
        e.n = 3'h2;
      end
    endcase
    if (t) begin
      e.r.pc = q.pc + (q.next_two_word ? 16'h0003 : 16'h0002);
      e.n = q.next_two_word ? 3'h3 : 3'h2;
    end
    return e;
  endfunction

  function automatic bmx_req_t gen(integer i);
    bmx_req_t    q;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    q = {a, b, c, c[25:0] ^ a[25:0]};
    q.op = bmx_op_t'(5'(a % 23 + 1));
    q.cond = bmx_cond_t'(5'(b % 20));
    if (c[31] || q.op == OP_SKIP_REG_BIT_CLEAR || q.op == OP_SKIP_REG_BIT_SET)
      q.rr = q.rd;
    if (q.op == OP_BRANCH) q.k = {{5{q.k[6]}}, q.k[6:0]};
    // Hand-picked corners ahead of the random traffic
    case (i)
      0: begin q.op = OP_COMPARE; q.rd = 8'h80; q.rr = 8'h01; end
      1: begin q.op = OP_COMPARE_WITH_CARRY; q.rr = q.rd; q.status = 8'h01; end
      2: begin q.op = OP_FRACTIONAL_MULTIPLY_SIGNED; q.rd = 8'h80; q.rr = 8'h80; end
      3: begin q.op = OP_RELATIVE_JUMP; q.pc = 16'h0000; q.k = 12'h800; end
      4: begin q.op = OP_COMPARE_SKIP_EQUAL; q.rr = q.rd; q.next_two_word = 1'b1; end
      5: begin q.op = OP_INTERRUPT_RETURN; q.status = 8'h00; end
      6: begin q.op = OP_BRANCH; q.cond = BR_SIGNED_GE; q.status = 8'h0c; end
      default: ;
    endcase
    return q;
  endfunction

  task automatic step();
    @(posedge clock);
    cyc++;
    // The request standing at this edge is taken once the last one is done
    if (req_valid && cyc > end_cyc) begin
      want = model(req);
      inflight = 1'b1;
      end_cyc = cyc + want.n;
    end
    if (cyc >= end_cyc) begin
      if ($random(seed) & 3) begin
        req <= gen(idx);
        idx++;
        req_valid <= 1'b1;
      end else begin
        req_valid <= 1'b0;
      end
    end else begin
      // Refused while busy
      req <= gen(99);
      req_valid <= 1'b1;
    end
    // Outputs launched at this edge are settled by the falling edge
    @(negedge clock);
    `TB_CHK(busy, 1'(cyc < end_cyc))
    `TB_CHK(res.done, 1'(inflight && cyc == end_cyc))
    if (inflight && cyc == end_cyc) begin
      `TB_CHK(res.pc, want.r.pc)
      `TB_CHK({res.pc_load, res.push_we, res.prod_we, res.status_we}, {want.r.pc_load, want.r.push_we, want.r.prod_we, want.r.status_we})
      if (want.r.push_we) `TB_CHK(res.push_pc, want.r.push_pc)
      if (want.r.prod_we) `TB_CHK(res.prod, want.r.prod)
      if (want.r.status_we) `TB_CHK(res.status, want.r.status)
      inflight = 1'b0;
    end else begin
      `TB_CHK({res.pc_load, res.push_we, res.prod_we, res.status_we}, 4'h0)
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    seed = 81728;
    mismatches = 0;
    cmp_count = 0;
    cyc = 0;
    end_cyc = 0;
    idx = 0;
    inflight = 1'b0;
    want = '0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 4000; i++) step();
    $display("Test random traffic with corners done");
    @(posedge clock);
    arst_n <= 1'b0;
    req_valid <= 1'b0;
    @(negedge clock);
    `TB_CHK({busy, res}, '0)
    inflight = 1'b0;
    @(posedge clock);
    arst_n <= 1'b1;
    cyc = 0;
    end_cyc = 0;
    $display("Test mid-run reset done");
    for (int i = 0; i < 1000; i++) step();
    $display("Test traffic after reset done");
    close_out();
  end
endmodule
